// ---- logic/strobe_ctrl_map.svh ----
// constants for the bus strobe, reset and interrupt control block
`ifndef STROBE_CTRL_MAP_SVH
`define STROBE_CTRL_MAP_SVH
`define ADDR_W            16
`define DATA_W            16
`define PORT_W            3
`define ONCHIP_WORDS      17'h02000
`define PC_RESET          16'h0000
`define CLK_DIV           4
`define DIV_W             2
`define DIV_LAST          2'h3
`define RESET_MIN_CYCLES  5
`define RST_CNT_W         3
`endif

// ---- logic/strobe_ctrl_pkg.sv ----
// types for the bus strobe, reset and interrupt control block
package strobe_ctrl_pkg;
    typedef enum logic [4:0] {
        OP_FETCH = 5'b00001,
        OP_IN    = 5'b00010,
        OP_OUT   = 5'b00100,
        OP_TABLE_WRITE_INSTR  = 5'b01000,
        OP_IDLE  = 5'b10000
    } cycle_kind_t;

    typedef enum logic [2:0] {
        ST_RESET  = 3'b001,
        ST_RESUME = 3'b010,
        ST_RUN    = 3'b100
    } run_state_t;
endpackage

// ---- logic/machine_clock_div.sv ----
// divide-by-four machine clock enable and clock output
`timescale 1ns/1ps
`include "strobe_ctrl_map.svh"
module machine_clock_div (
    input  wire logic clock,
    input  wire logic reset,
    output logic      machineTick,
    output logic      machineClockOut
);
    logic [`DIV_W-1:0] divCount_r;

    // ---------------------------------------------------
    // divider
    // ---------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            divCount_r <= '0;
        end else begin
            divCount_r <= divCount_r + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            machineTick     <= 1'b0;
            machineClockOut <= 1'b0;
        end else begin
            machineTick     <= (divCount_r == `DIV_LAST);
            machineClockOut <= divCount_r[`DIV_W-1];
        end
    end
endmodule

// ---- logic/dsp_bus_strobe_ctrl.sv ----
// external bus strobes, poll branch, interrupt flag, map select and reset sequence
`timescale 1ns/1ps
`include "strobe_ctrl_map.svh"
module dsp_bus_strobe_ctrl
    import strobe_ctrl_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                device_init_n,
    input  wire logic                memory_map_select,
    input  wire logic                branch_poll_in_n,
    input  wire logic                irqIn_n,
    input  wire logic                irqGrant,
    input  wire logic                irqEnableSet,
    input  wire logic                overflowModeSet,
    input  wire logic                overflowModeValue,
    input  wire logic [4:0]          cycleKind,
    input  wire logic                branch_on_poll_low_instr,
    input  wire logic [`ADDR_W-1:0]  branchTarget,
    input  wire logic [`ADDR_W-1:0]  nextPc,
    input  wire logic [`PORT_W-1:0]  portSelect,
    input  wire logic [`DATA_W-1:0]  writeData,
    input  wire logic [`DATA_W-1:0]  dataIn,
    output logic [`ADDR_W-1:0]       addressOut,
    output logic [`ADDR_W-1:0]       programCounter,
    output logic [`DATA_W-1:0]       dataOut,
    output logic                     dataOe,
    output logic [`DATA_W-1:0]       portReadData,
    output logic                     fetch_strobe_n,
    output logic                     port_read_strobe_n,
    output logic                     port_write_strobe_n,
    output logic                     prog_mem_write_strobe_n,
    output logic                     fetchOnChip,
    output logic                     irq_pending_flag,
    output logic                     irqRequest,
    output logic                     irqEnabled,
    output logic                     overflowMode,
    output logic                     machine_clock_out,
    output logic                     running,
    output logic                     branchTaken
);
    run_state_t                 state_r;
    run_state_t                 state_nxt;
    logic [`RST_CNT_W-1:0]      rstCount_r;
    logic                       irqPrev_r;
    logic                       tick;
    logic                       execOk;
    logic [`ADDR_W-1:0]         pcNext;
    cycle_kind_t                kind;

    assign kind   = cycle_kind_t'(cycleKind);
    assign execOk = (state_r == ST_RUN) && tick;

    // ---------------------------------------------------
    // machine clock
    // ---------------------------------------------------
    machine_clock_div u_div (
        .clock           (clock),
        .reset           (reset),
        .machineTick     (tick),
        .machineClockOut (machine_clock_out)
    );

    // ---------------------------------------------------
    // reset sequence
    // ---------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                // short pulses are ignored; below five cycles the reset is not honoured
                if (device_init_n && rstCount_r >= `RST_CNT_W'(`RESET_MIN_CYCLES)) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_RESUME: begin
                if (tick) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
        if (!device_init_n && rstCount_r >= `RST_CNT_W'(`RESET_MIN_CYCLES - 1)) begin
            state_nxt = ST_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r    <= ST_RESET;
            rstCount_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (device_init_n) begin
                rstCount_r <= '0;
            end else if (rstCount_r != `RST_CNT_W'(`RESET_MIN_CYCLES)) begin
                rstCount_r <= rstCount_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            running <= 1'b0;
        end else begin
            running <= (state_nxt == ST_RUN);
        end
    end

    // ---------------------------------------------------
    // program counter and address bus
    // ---------------------------------------------------
    always_comb begin
        pcNext = nextPc;
        if (kind == OP_FETCH && branch_on_poll_low_instr && !branch_poll_in_n) begin
            pcNext = branchTarget;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || state_r == ST_RESET) begin
            programCounter <= `PC_RESET;
            addressOut     <= `PC_RESET;
            branchTaken    <= 1'b0;
            fetchOnChip    <= 1'b0;
        end else if (execOk) begin
            // only a fetch can branch; other cycles drop the flag
            branchTaken <= (kind == OP_FETCH) && branch_on_poll_low_instr && !branch_poll_in_n;
            if (kind == OP_IN || kind == OP_OUT) begin
                addressOut <= {{(`ADDR_W-`PORT_W){1'b0}}, portSelect};
            end else if (kind == OP_FETCH) begin
                programCounter <= pcNext;
                addressOut     <= programCounter;
                // internal words only exist in microcomputer mode
                fetchOnChip    <= memory_map_select
                                  && ({1'b0, programCounter} < `ONCHIP_WORDS);
            end
        end
    end

    // ---------------------------------------------------
    // strobes and data bus
    // ---------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset || state_r != ST_RUN || !device_init_n) begin
            fetch_strobe_n          <= 1'b1;
            port_read_strobe_n      <= 1'b1;
            port_write_strobe_n     <= 1'b1;
            prog_mem_write_strobe_n <= 1'b1;
            dataOe                  <= 1'b0;
            dataOut                 <= '0;
        end else if (tick) begin
            // one-hot kind keeps at most one strobe low
            fetch_strobe_n          <= !(kind == OP_FETCH);
            port_read_strobe_n      <= !(kind == OP_IN);
            port_write_strobe_n     <= !(kind == OP_OUT);
            prog_mem_write_strobe_n <= !(kind == OP_TABLE_WRITE_INSTR);
            dataOe                  <= (kind == OP_OUT) || (kind == OP_TABLE_WRITE_INSTR);
            dataOut                 <= writeData;
        end
    end

    // relies on the port driving the bus while the read strobe is low
    always_ff @(posedge clock) begin
        if (reset) begin
            portReadData <= '0;
        end else if (!port_read_strobe_n) begin
            portReadData <= dataIn;
        end
    end

    // ---------------------------------------------------
    // interrupt
    // ---------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            irqPrev_r        <= 1'b1;
            irq_pending_flag <= 1'b0;
            irqEnabled       <= 1'b0;
            irqRequest       <= 1'b0;
        end else begin
            irqPrev_r <= irqIn_n;
            if (state_r == ST_RESET) begin
                irq_pending_flag <= 1'b0;
                irqEnabled       <= 1'b0;
                irqRequest       <= 1'b0;
            end else begin
                // new edge wins over a grant in the same cycle
                if (irqPrev_r && !irqIn_n) begin
                    irq_pending_flag <= 1'b1;
                end else if (irqGrant) begin
                    irq_pending_flag <= 1'b0;
                end
                if (irqEnableSet) begin
                    irqEnabled <= 1'b1;
                end else if (irqGrant) begin
                    irqEnabled <= 1'b0;
                end
                irqRequest <= irqEnabled && (irq_pending_flag || !irqIn_n);
            end
        end
    end

    // overflow mode survives device reset; of the two resets only the system reset clears it
    always_ff @(posedge clock) begin
        if (reset) begin
            overflowMode <= 1'b0;
        end else if (overflowModeSet && state_r != ST_RESET) begin
            overflowMode <= overflowModeValue;
        end
    end
endmodule

// ---- verification/strobe_ctrl_checker.sv ----
// concurrent checks on the strobe, reset and interrupt block ports
`timescale 1ns/1ps
module strobe_ctrl_checker (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        device_init_n,
    input wire logic        irqIn_n,
    input wire logic        irqGrant,
    input wire logic [15:0] addressOut,
    input wire logic [15:0] programCounter,
    input wire logic        dataOe,
    input wire logic        fetch_strobe_n,
    input wire logic        port_read_strobe_n,
    input wire logic        port_write_strobe_n,
    input wire logic        prog_mem_write_strobe_n,
    input wire logic        irq_pending_flag,
    input wire logic        irqEnabled,
    input wire logic        machine_clock_out,
    input wire logic        running
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire logic [3:0] lowN = ~{fetch_strobe_n, port_read_strobe_n, port_write_strobe_n, prog_mem_write_strobe_n};
    chk_strobe_mutex: assert property ($countones(lowN) <= 1)
        else $error("two strobes low");
    chk_data_drive: assert property (dataOe == (lowN[1] || lowN[0]))
        else $error("data drive outside write strobe");
    chk_port_addr: assert property (lowN[2] || lowN[1] |-> addressOut[15:3] == 13'h0000)
        else $error("port cycle upper address not low");
    chk_init_quiet: assert property (!device_init_n |=> lowN == 4'h0 && !dataOe)
        else $error("strobes or data active in device reset");
    chk_init_hold: assert property ((!device_init_n)[*6] |=> !running && programCounter == 16'h0000
        && addressOut == 16'h0000 && !irq_pending_flag && !irqEnabled) else $error("reset state not kept");
    chk_irq_latch: assert property ($fell(irqIn_n) && running |-> ##[1:3] irq_pending_flag)
        else $error("falling edge not latched");
    chk_flag_hold: assert property (irq_pending_flag && !irqGrant && running |=> irq_pending_flag)
        else $error("pending flag lost before grant");
    chk_grant_clear: assert property (irqIn_n[*3] ##0 irqGrant |=> !irq_pending_flag)
        else $error("grant did not clear flag");
    chk_clock_div: assert property ($rose(machine_clock_out) |-> machine_clock_out ##1 machine_clock_out
        ##1 !machine_clock_out ##1 !machine_clock_out ##1 machine_clock_out) else $error("machine clock not div4");
endmodule
bind dsp_bus_strobe_ctrl strobe_ctrl_checker chk_u (.*);

// ---- verification/port_peripheral_model.sv ----
// external input port model facing the shared data bus
`timescale 1ns/1ps
module port_peripheral_model #(
    parameter logic [15:0] PORT_BASE = 16'hC3A0
) (
    input  wire logic        clock,
    input  wire logic        port_read_strobe_n,
    input  wire logic [15:0] addressOut,
    output logic      [15:0] dataIn
);
    // released bus shows the inverse so a stale value cannot pass for a read
    assign dataIn = port_read_strobe_n ? ~(PORT_BASE + addressOut) : PORT_BASE + addressOut;
endmodule

// ---- verification/dsp_bus_strobe_ctrl_tb.sv ----
// self-checking bench for the strobe, reset and interrupt block
`timescale 1ns/1ps
module dsp_bus_strobe_ctrl_tb;
    import strobe_ctrl_pkg::*;
    localparam logic [15:0] PORT_BASE = 16'hC3A0;
    logic clock = 1'h0, reset = 1'h1, device_init_n = 1'h0, memory_map_select = 1'h1;
    logic branch_poll_in_n = 1'h1, irqIn_n = 1'h1, irqGrant = 1'h0, irqEnableSet = 1'h0;
    logic overflowModeSet = 1'h0, overflowModeValue = 1'h0, branch_on_poll_low_instr = 1'h0;
    logic [4:0] cycleKind = OP_IDLE;
    logic [2:0] portSelect = 3'h0;
    logic [15:0] branchTarget = 16'h0, nextPc = 16'h0, writeData = 16'h0, expPc = 16'h0;
    logic [15:0] dataIn, addressOut, programCounter, dataOut, portReadData;
    logic dataOe, fetch_strobe_n, port_read_strobe_n, port_write_strobe_n, prog_mem_write_strobe_n;
    logic fetchOnChip, irq_pending_flag, irqRequest, irqEnabled, overflowMode, machine_clock_out;
    logic running, branchTaken;
    int err_total = 0, num_checks = 0;
    wire logic [3:0] strobesN = {prog_mem_write_strobe_n, port_write_strobe_n, port_read_strobe_n, fetch_strobe_n};
    dsp_bus_strobe_ctrl dut_u (.*);
    port_peripheral_model #(.PORT_BASE(PORT_BASE)) peer_u (.*);
    always #4 clock = ~clock;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one machine cycle; aligned means the previous call left us on its phase
    task automatic bus_cycle(input logic [4:0] kind, input bit aligned);
        int n;
        cycleKind = kind;
        if (aligned) repeat (3) @(negedge clock);
        for (n = 0; n < 16 && strobesN !== ~kind[3:0]; n++) @(negedge clock);
        chk(16'(strobesN), 16'({~kind[3:0]}), "strobes");
        chk(16'(branchTaken), 16'(kind[0] && branch_on_poll_low_instr && !branch_poll_in_n), "branch taken");
        if (kind[0]) begin
            chk(addressOut, expPc, "fetch address");
            chk(16'(fetchOnChip), 16'(memory_map_select && expPc < 16'h2000), "on-chip");
            expPc = (branch_on_poll_low_instr && !branch_poll_in_n) ? branchTarget : nextPc;
        end
        if (kind[1] || kind[2]) chk(addressOut, {13'h0000, portSelect}, "port address");
        if (kind[2] || kind[3]) chk(dataOut, writeData, "write data");
        chk(16'(dataOe), 16'(kind[2] || kind[3]), "data drive");
        @(negedge clock);
        if (kind[0]) chk(programCounter, expPc, "pc");
        if (kind[1]) chk(portReadData, PORT_BASE + {13'h0000, portSelect}, "read data");
    endtask
    task automatic run_random(input int cnt, input bit aligned0);
        for (int i = 0; i < cnt; i++) begin
            {portSelect, memory_map_select, branch_on_poll_low_instr, branch_poll_in_n} = 6'($urandom);
            {writeData, nextPc} = $urandom;
            branchTarget = 16'($urandom);
            // boundary of the on-chip region
            if (i % 8 == 3) nextPc = i[4] ? 16'h1FFF : 16'h2000;
            bus_cycle(5'h01 << $urandom_range(3, 0), i > 0 || aligned0);
        end
        $display("random cycles done");
    endtask
    task automatic irq_test;
        repeat (8) @(negedge clock);
        irqEnableSet = 1'h1;
        @(negedge clock) irqEnableSet = 1'h0;
        irqIn_n = 1'h0;
        repeat (4) @(negedge clock);
        chk(16'(irq_pending_flag), 16'h1, "flag set");
        chk(16'(irqRequest), 16'h1, "request");
        irqIn_n = 1'h1;
        repeat (8) @(negedge clock);
        chk(16'(irq_pending_flag), 16'h1, "flag held");
        irqGrant = 1'h1;
        @(negedge clock) irqGrant = 1'h0;
        @(negedge clock);
        chk(16'(irq_pending_flag), 16'h0, "flag cleared");
        irqIn_n = 1'h0;
        repeat (4) @(negedge clock);
        chk(16'(irq_pending_flag), 16'h1, "flag set again");
        // grant while the line stays low: only the level can request now
        irqGrant = 1'h1;
        @(negedge clock) irqGrant = 1'h0;
        irqEnableSet = 1'h1;
        @(negedge clock) irqEnableSet = 1'h0;
        @(negedge clock);
        chk(16'(irq_pending_flag), 16'h0, "flag cleared, line low");
        chk(16'(irqRequest), 16'h1, "level request");
        irqIn_n = 1'h1;
        $display("interrupt test done");
    endtask
    task automatic init_test;
        overflowModeValue = 1'h1;
        overflowModeSet = 1'h1;
        // pending flag and enable are both up when the device reset hits
        irqIn_n = 1'h0;
        @(negedge clock) overflowModeSet = 1'h0;
        irqIn_n = 1'h1;
        device_init_n = 1'h0;
        repeat (2) @(negedge clock);
        chk(16'(irq_pending_flag), 16'h1, "flag before clear");
        chk(16'(strobesN), 16'h000F, "strobes in reset");
        chk(16'(dataOe), 16'h0, "bus released");
        repeat (30) @(negedge clock);
        chk(16'(running), 16'h0, "held in reset");
        chk(programCounter | addressOut, 16'h0, "pc cleared");
        chk(16'({irqEnabled, irq_pending_flag, overflowMode}), 16'h1, "irq off, mode kept");
        device_init_n = 1'h1;
        expPc = 16'h0000;
        bus_cycle(OP_FETCH, 1'b0);
        $display("device reset test done");
    endtask
    initial begin
        void'($urandom(32'hE321F479));
        repeat (5) @(negedge clock);
        reset = 1'h0;
        repeat (6) @(negedge clock);
        device_init_n = 1'h1;
        irq_test;
        run_random(120, 1'b0);
        init_test;
        run_random(80, 1'b1);
        report_and_stop;
    end
    initial begin
        #100us;
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop;
    end
endmodule
